// ==== core/pcg_clk_gate.sv ====
// Glitch-free clock gate: enable latched only while the source clock is low
`default_nettype none
module pcg_clk_gate (
    input wire logic clk_in,
    input wire logic enable,
    output logic clk_out
);
    logic en_latch;

    // Transparent-low latch keeps the enable steady through the high phase
    always_latch begin
        if (!clk_in) begin
            en_latch <= enable; // see (R10)
        end
    end

    assign clk_out = clk_in & en_latch; // see (R1)
endmodule : pcg_clk_gate
`default_nettype wire

// ==== core/pcg_pkg.sv ====
// Package for the peripheral clock gating block: offsets, field positions, types
`default_nettype none
package pcg_pkg;
    localparam logic [7:0] PCG_OFF_CTL3 = 8'h00;
    localparam logic [7:0] PCG_OFF_CTL4 = 8'h04;
    localparam logic [7:0] PCG_OFF_STATUS = 8'h08;
    localparam int PCG_BIT_CMP = 10;
    localparam int PCG_BIT_REFCLK = 3;
    localparam logic [15:0] PCG_CTL3_MASK = 16'h0400;
    localparam logic [15:0] PCG_CTL4_MASK = 16'h0008;
    localparam logic [15:0] PCG_CTL_RESET = 16'h0000;
    // One instruction cycle of delay between a write and the gate change
    localparam int PCG_INSTR_CYCLE_NS = 10;
    localparam int PCG_CLK_PERIOD_NS = 10;
    localparam int PCG_SWITCH_CYCLES = (PCG_INSTR_CYCLE_NS + PCG_CLK_PERIOD_NS - 1) / PCG_CLK_PERIOD_NS;
    localparam logic [1:0] PCG_HTRANS_NONSEQ = 2'h2;
    localparam int PCG_NUM_MODULES = 2;
    localparam int PCG_IDX_CMP = 0;
    localparam int PCG_IDX_REFCLK = 1;

    typedef struct packed {
        logic [1:0] htrans;
        logic [7:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
    } pcg_addr_t;

    typedef struct packed {
        logic cmp_on;
        logic refclk_on;
    } pcg_enables_t;

    typedef enum logic [1:0] {
        PCG_PH_IDLE = 2'b00,
        PCG_PH_WRITE = 2'b01,
        PCG_PH_READ = 2'b10
    } pcg_phase_t;
endpackage : pcg_pkg
`default_nettype wire

// ==== core/pcg_top.sv ====
// Peripheral module disable registers with per-module clock gates on AHB-Lite
// Behaviour
// (R1) Disabled module receives no clock at all
// (R2) Disabled module's register writes are blocked
// (R3) Enabled only if bit clear and present
// (R4) Present modules' disable bits clear at reset
// (R5) Setting bit stops module one cycle later
// (R6) Clearing bit restarts module one cycle later
// (R7) Control 3 bit 10 gates comparator
// (R8) Control 4 bit 3 gates reference clock
// (R9) Unused bits ignore writes, read zero
// (R10) Gate switches only while clock low
`default_nettype none
module pcg_top #(
    parameter bit CMP_PRESENT = 1'b1,
    parameter bit REFCLK_PRESENT = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic cmp_clk,
    output logic refclk_gen_clk,
    output pcg_pkg::pcg_enables_t module_active,
    output logic cmp_reg_wr_allow,
    output logic refclk_reg_wr_allow
);
    import pcg_pkg::*;

    // The gate follows its bit after exactly one edge; a faster core clock would need a counter
    if (PCG_SWITCH_CYCLES != 1) begin : g_bad_switch
        $error("pcg_top: switch delay must be one cycle");
    end

    // Outputs and status bits below name exactly two modules
    if (PCG_NUM_MODULES != 2) begin : g_bad_count
        $error("pcg_top: the block serves exactly two modules");
    end

    logic [15:0] ctl3_r;
    logic [15:0] ctl4_r;
    pcg_addr_t addr_r;
    pcg_phase_t phase_r;
    logic comparator_gate_off;
    logic refclock_gen_gate_off;
    logic [PCG_NUM_MODULES-1:0] present;
    logic [PCG_NUM_MODULES-1:0] gate_off;
    logic [PCG_NUM_MODULES-1:0] enable_r;
    logic [PCG_NUM_MODULES-1:0] gated_clk;
    logic [31:0] rdata_nxt;
    logic take;
    logic rd_take;
    logic wr_ctl3;
    logic wr_ctl4;
    logic wr_other;
    logic [15:0] ctl3_nxt;
    logic [15:0] ctl4_nxt;

    assign take = hsel & hready & (htrans == PCG_HTRANS_NONSEQ);
    assign rd_take = take & ~hwrite;

    // Address phase captured for use in the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= '0;
            phase_r <= PCG_PH_IDLE;
        end else if (hready) begin
            addr_r <= '{htrans: htrans, haddr: haddr, hwrite: hwrite, hsize: hsize, hsel: hsel};
            if (take) begin
                phase_r <= hwrite ? PCG_PH_WRITE : PCG_PH_READ;
            end else begin
                phase_r <= PCG_PH_IDLE;
            end
        end
    end

    // Write decode for the data phase that follows an accepted write
    assign wr_ctl3 = (phase_r == PCG_PH_WRITE) && (addr_r.haddr == PCG_OFF_CTL3);
    assign wr_ctl4 = (phase_r == PCG_PH_WRITE) && (addr_r.haddr == PCG_OFF_CTL4);
    assign wr_other = (phase_r == PCG_PH_WRITE) && !wr_ctl3 && !wr_ctl4;

    // Only implemented bits are stored; absent modules keep their bit clear
    always_comb begin
        ctl3_nxt = ctl3_r;
        ctl4_nxt = ctl4_r;
        if (wr_ctl3) begin
            ctl3_nxt = hwdata[15:0] & PCG_CTL3_MASK & {16{CMP_PRESENT}}; // see (R9)
        end
        if (wr_ctl4) begin
            ctl4_nxt = hwdata[15:0] & PCG_CTL4_MASK & {16{REFCLK_PRESENT}}; // see (R9)
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl3_r <= PCG_CTL_RESET; // see (R4)
        end else begin
            ctl3_r <= ctl3_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl4_r <= PCG_CTL_RESET; // see (R4)
        end else begin
            ctl4_r <= ctl4_nxt;
        end
    end

    assign comparator_gate_off = ctl3_r[PCG_BIT_CMP]; // see (R7)
    assign refclock_gen_gate_off = ctl4_r[PCG_BIT_REFCLK]; // see (R8)
    assign gate_off[PCG_IDX_CMP] = comparator_gate_off;
    assign gate_off[PCG_IDX_REFCLK] = refclock_gen_gate_off;
    assign present[PCG_IDX_CMP] = CMP_PRESENT;
    assign present[PCG_IDX_REFCLK] = REFCLK_PRESENT;

    // The register write lands at one edge, the gate follows at the next
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_r <= '0;
        end else begin
            enable_r <= present & ~gate_off; // see (R3) (R5) (R6)
        end
    end

    genvar g;
    generate
        for (g = 0; g < PCG_NUM_MODULES; g++) begin : g_gate
            pcg_clk_gate u_gate (
                .clk_in(hclk),
                .enable(enable_r[g]),
                .clk_out(gated_clk[g])
            );

            // An enabled module sees every high phase, a disabled one none
            chk_gate_run: assert property (@(negedge hclk) disable iff (!hresetn) // see (R1) (R10)
                enable_r[g] |-> ##1 gated_clk[g])
                else $error("gated clock missing a pulse while enabled");

            chk_gate_stop: assert property (@(negedge hclk) disable iff (!hresetn) // see (R1) (R10)
                !enable_r[g] |-> ##1 !gated_clk[g])
                else $error("gated clock pulsing while disabled");
        end
    endgenerate

    assign cmp_clk = gated_clk[PCG_IDX_CMP]; // see (R1)
    assign refclk_gen_clk = gated_clk[PCG_IDX_REFCLK]; // see (R1)
    assign module_active.cmp_on = enable_r[PCG_IDX_CMP];
    assign module_active.refclk_on = enable_r[PCG_IDX_REFCLK];
    // Peripheral register files must honour these; their clock is stopped anyway
    assign cmp_reg_wr_allow = enable_r[PCG_IDX_CMP]; // see (R2)
    assign refclk_reg_wr_allow = enable_r[PCG_IDX_REFCLK]; // see (R2)

    // Next values are read so a read right behind a write to the same register is not stale
    always_comb begin
        rdata_nxt = 32'h00000000;
        case (haddr)
            PCG_OFF_CTL3: rdata_nxt = {16'h0000, ctl3_nxt}; // see (R9)
            PCG_OFF_CTL4: rdata_nxt = {16'h0000, ctl4_nxt}; // see (R9)
            PCG_OFF_STATUS: rdata_nxt = {30'h00000000, enable_r};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Read data registered at the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_take) begin
            hrdata <= rdata_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    chk_cmp_off_delay: assert property (@(posedge hclk) disable iff (!hresetn) // see (R5)
        $rose(comparator_gate_off) |=> !enable_r[PCG_IDX_CMP])
        else $error("comparator not stopped one cycle after disable");

    chk_cmp_on_delay: assert property (@(posedge hclk) disable iff (!hresetn) // see (R6)
        ($fell(comparator_gate_off) && CMP_PRESENT) |=> enable_r[PCG_IDX_CMP])
        else $error("comparator not restarted one cycle after enable");

    chk_ref_follow: assert property (@(posedge hclk) disable iff (!hresetn) // see (R8)
        $past(hresetn) |-> enable_r[PCG_IDX_REFCLK] == $past(REFCLK_PRESENT && !ctl4_r[PCG_BIT_REFCLK]))
        else $error("reference clock enable does not follow its bit");

    chk_absent_off: assert property (@(posedge hclk) disable iff (!hresetn) // see (R3)
        !CMP_PRESENT |-> !enable_r[PCG_IDX_CMP] && !comparator_gate_off)
        else $error("absent comparator shown enabled");

    chk_unused_zero: assert property (@(posedge hclk) disable iff (!hresetn) // see (R9)
        ((ctl3_r & ~PCG_CTL3_MASK) == 16'h0000) && ((ctl4_r & ~PCG_CTL4_MASK) == 16'h0000))
        else $error("unused disable bit set");

    sequence s_cmp_write_set;
        phase_r == PCG_PH_WRITE && addr_r.haddr == PCG_OFF_CTL3 && hwdata[PCG_BIT_CMP] && CMP_PRESENT;
    endsequence

    chk_cmp_bit_store: assert property (@(posedge hclk) disable iff (!hresetn) // see (R7)
        s_cmp_write_set |=> comparator_gate_off ##1 !enable_r[PCG_IDX_CMP])
        else $error("comparator disable bit write not effective");

    chk_wr_block: assert property (@(posedge hclk) disable iff (!hresetn) // see (R2)
        comparator_gate_off |=> !cmp_reg_wr_allow)
        else $error("comparator register writes allowed while disabled");

    chk_clk_stop: assert property (@(negedge hclk) disable iff (!hresetn) // see (R1)
        !enable_r[PCG_IDX_CMP] |-> ##1 !cmp_clk)
        else $error("comparator clock running while disabled");

    chk_reset_clear: assert property (@(posedge hclk) // see (R4)
        $rose(hresetn) |-> ctl3_r == PCG_CTL_RESET && ctl4_r == PCG_CTL_RESET)
        else $error("disable bits not clear after reset");

    // The first edge after release loads the enables, so they are checked one edge later
    chk_reset_enables: assert property (@(posedge hclk) disable iff (!hresetn) // see (R3) (R4)
        ($past(hresetn) && !$past(hresetn, 2)) |-> enable_r == present)
        else $error("present modules not enabled after reset");

    chk_ref_off_delay: assert property (@(posedge hclk) disable iff (!hresetn) // see (R5)
        $rose(refclock_gen_gate_off) |=> !enable_r[PCG_IDX_REFCLK])
        else $error("reference clock generator not stopped one cycle after disable");

    chk_ref_on_delay: assert property (@(posedge hclk) disable iff (!hresetn) // see (R6)
        ($fell(refclock_gen_gate_off) && REFCLK_PRESENT) |=> enable_r[PCG_IDX_REFCLK])
        else $error("reference clock generator not restarted one cycle after enable");

    chk_cmp_follow: assert property (@(posedge hclk) disable iff (!hresetn) // see (R7)
        $past(hresetn) |-> enable_r[PCG_IDX_CMP] == $past(CMP_PRESENT && !ctl3_r[PCG_BIT_CMP]))
        else $error("comparator enable does not follow its bit");

    sequence s_cmp_write_clr;
        phase_r == PCG_PH_WRITE && addr_r.haddr == PCG_OFF_CTL3 && !hwdata[PCG_BIT_CMP] && CMP_PRESENT;
    endsequence

    chk_cmp_bit_clear: assert property (@(posedge hclk) disable iff (!hresetn) // see (R6) (R7)
        s_cmp_write_clr |=> !comparator_gate_off ##1 enable_r[PCG_IDX_CMP])
        else $error("comparator enable bit write not effective");

    sequence s_ref_write_set;
        phase_r == PCG_PH_WRITE && addr_r.haddr == PCG_OFF_CTL4 && hwdata[PCG_BIT_REFCLK] && REFCLK_PRESENT;
    endsequence

    chk_ref_bit_store: assert property (@(posedge hclk) disable iff (!hresetn) // see (R5) (R8)
        s_ref_write_set |=> refclock_gen_gate_off ##1 !enable_r[PCG_IDX_REFCLK])
        else $error("reference clock disable bit write not effective");

    sequence s_ref_write_clr;
        phase_r == PCG_PH_WRITE && addr_r.haddr == PCG_OFF_CTL4 && !hwdata[PCG_BIT_REFCLK] && REFCLK_PRESENT;
    endsequence

    chk_ref_bit_clear: assert property (@(posedge hclk) disable iff (!hresetn) // see (R6) (R8)
        s_ref_write_clr |=> !refclock_gen_gate_off ##1 enable_r[PCG_IDX_REFCLK])
        else $error("reference clock enable bit write not effective");

    chk_ref_wr_block: assert property (@(posedge hclk) disable iff (!hresetn) // see (R2)
        refclock_gen_gate_off |=> !refclk_reg_wr_allow)
        else $error("reference clock register writes allowed while disabled");

    chk_cmp_allow_on: assert property (@(posedge hclk) disable iff (!hresetn) // see (R2) (R3)
        (!comparator_gate_off && CMP_PRESENT) |=> cmp_reg_wr_allow)
        else $error("comparator register writes blocked while enabled");

    chk_ref_allow_on: assert property (@(posedge hclk) disable iff (!hresetn) // see (R2) (R3)
        (!refclock_gen_gate_off && REFCLK_PRESENT) |=> refclk_reg_wr_allow)
        else $error("reference clock register writes blocked while enabled");

    chk_ref_clk_stop: assert property (@(negedge hclk) disable iff (!hresetn) // see (R1)
        !enable_r[PCG_IDX_REFCLK] |-> ##1 !refclk_gen_clk)
        else $error("reference clock running while disabled");

    chk_absent_ref: assert property (@(posedge hclk) disable iff (!hresetn) // see (R3)
        !REFCLK_PRESENT |-> !enable_r[PCG_IDX_REFCLK] && !refclock_gen_gate_off)
        else $error("absent reference clock generator shown enabled");

    // Read data phase: unimplemented bits read zero and the value is never stale
    sequence s_read_of(logic [7:0] a);
        rd_take && haddr == a;
    endsequence

    chk_rd_ctl3_zero: assert property (@(posedge hclk) disable iff (!hresetn) // see (R9)
        s_read_of(PCG_OFF_CTL3) |=> (hrdata & ~{16'h0000, PCG_CTL3_MASK}) == 32'h00000000)
        else $error("unused control 3 bit read as one");

    chk_rd_ctl4_zero: assert property (@(posedge hclk) disable iff (!hresetn) // see (R9)
        s_read_of(PCG_OFF_CTL4) |=> (hrdata & ~{16'h0000, PCG_CTL4_MASK}) == 32'h00000000)
        else $error("unused control 4 bit read as one");

    chk_rd_ctl3_fresh: assert property (@(posedge hclk) disable iff (!hresetn) // see (R7)
        s_read_of(PCG_OFF_CTL3) |=> hrdata[15:0] == ctl3_r)
        else $error("control 3 read data stale");

    chk_rd_ctl4_fresh: assert property (@(posedge hclk) disable iff (!hresetn) // see (R8)
        s_read_of(PCG_OFF_CTL4) |=> hrdata[15:0] == ctl4_r)
        else $error("control 4 read data stale");

    chk_rd_status: assert property (@(posedge hclk) disable iff (!hresetn) // see (R3)
        s_read_of(PCG_OFF_STATUS) |=> hrdata == {30'h00000000, $past(enable_r)})
        else $error("status read does not show the enables");

    chk_rd_unmapped: assert property (@(posedge hclk) disable iff (!hresetn) // see (R9)
        (rd_take && haddr != PCG_OFF_CTL3 && haddr != PCG_OFF_CTL4 && haddr != PCG_OFF_STATUS)
        |=> hrdata == 32'h00000000)
        else $error("unmapped address read not zero");

    chk_other_wr_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // see (R9)
        wr_other |=> $stable(ctl3_r) && $stable(ctl4_r))
        else $error("write to another address changed a disable bit");

    chk_steady_enables: assert property (@(posedge hclk) disable iff (!hresetn) // see (R5) (R6)
        ($past(hresetn) && $stable(ctl3_r) && $stable(ctl4_r)) |=> $stable(enable_r))
        else $error("enables moved with no change of their bits");

    chk_idle_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        (hready && !take) |=> phase_r == PCG_PH_IDLE)
        else $error("data phase started without an accepted transfer");

    chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule : pcg_top
`default_nettype wire

// ==== tb/test_pcg_top.sv ====
// Self-checking testbench for the peripheral clock gating block
`default_nettype none
module test_pcg_top import pcg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0] a;
        logic [31:0] wd;
        logic [31:0] er;
        logic [1:0] act;
    } pcg_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, cmp_clk, refclk_gen_clk, cmp_reg_wr_allow, refclk_reg_wr_allow;
    pcg_enables_t module_active, absent_active;
    logic absent_wr;
    int err_total = 0, tests_run = 0, cyc = 0;
    // Rows: write address, written word, read-back of that address, expected {cmp, refclk} enables
    pcg_row_t rows [7] = '{
        '{PCG_OFF_CTL3, 32'hFFFFFFFF, 32'h00000400, 2'b01},
        '{PCG_OFF_CTL4, 32'hFFFFFFFF, 32'h00000008, 2'b00},
        '{PCG_OFF_CTL3, 32'h0000FBFF, 32'h00000000, 2'b10},
        '{PCG_OFF_STATUS, 32'hFFFFFFFF, 32'h00000001, 2'b10},
        '{8'h0C, 32'hFFFFFFFF, 32'h00000000, 2'b10},
        '{PCG_OFF_CTL4, 32'h0000FFF7, 32'h00000000, 2'b11},
        '{PCG_OFF_CTL3, 32'h00000400, 32'h00000400, 2'b01}};

    assign hready = hreadyout;

    initial forever #5 hclk = ~hclk;

    pcg_top i_pcg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmp_clk(cmp_clk), .refclk_gen_clk(refclk_gen_clk),
        .module_active(module_active), .cmp_reg_wr_allow(cmp_reg_wr_allow),
        .refclk_reg_wr_allow(refclk_reg_wr_allow));

    // Variant without a comparator shares the bus; its comparator must never come up
    pcg_top #(.CMP_PRESENT(1'b0), .REFCLK_PRESENT(1'b1)) i_pcg_top_absent (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(), .hreadyout(), .hresp(), .cmp_clk(), .refclk_gen_clk(),
        .module_active(absent_active), .cmp_reg_wr_allow(absent_wr), .refclk_reg_wr_allow());

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Called in the time step of a rising edge; returns at the data-phase edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= PCG_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task do_reset;
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        chk({30'h0, module_active}, 32'h0, "in reset");
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, PCG_OFF_CTL3, 32'h0);
        chk(rd, 32'h0, "ctl3 reset");
        bus(1'b0, PCG_OFF_CTL4, 32'h0);
        chk(rd, 32'h0, "ctl4 reset");
        chk({30'h0, module_active}, 32'h3, "reset enables");
        $display("reset test done");
    endtask : do_reset

    // Gated clocks are looked at mid-phase, well clear of the gate's switching point
    // One extra edge lets the enable of the last write reach the gate's latch
    task gate_check(input logic [1:0] on);
        @(posedge hclk);
        repeat (3) begin
            @(posedge hclk);
            #2;
            chk({30'h0, cmp_clk, refclk_gen_clk}, {30'h0, on}, "gated high");
            @(negedge hclk);
            #2;
            chk({30'h0, cmp_clk, refclk_gen_clk}, 32'h0, "gated low");
        end
        @(posedge hclk);
    endtask : gate_check

    task test_done;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        do_reset();
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].wd);
            bus(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].er, "readback");
            chk({30'h0, module_active}, {30'h0, rows[i].act}, "enables");
            chk({30'h0, cmp_reg_wr_allow, refclk_reg_wr_allow}, {30'h0, rows[i].act}, "wr allow");
            chk({29'h0, absent_active, absent_wr}, {29'h0, 1'b0, rows[i].act[0], 1'b0}, "absent");
            bus(1'b0, PCG_OFF_STATUS, 32'h0);
            chk(rd, {30'h0, rows[i].act[0], rows[i].act[1]}, "status");
            chk({31'h0, hresp}, 32'h0, "resp");
            $display("row %0d done", i);
        end
        // Comparator off now; clearing its bit must take effect one edge after the write
        bus(1'b1, PCG_OFF_CTL3, 32'h0);
        #1;
        chk({30'h0, module_active}, 32'h1, "before enable");
        @(posedge hclk);
        #1;
        chk({30'h0, module_active}, 32'h3, "after enable");
        gate_check(2'b11);
        bus(1'b1, PCG_OFF_CTL3, 32'h00000400);
        #1;
        chk({30'h0, module_active}, 32'h3, "before disable");
        @(posedge hclk);
        #1;
        chk({30'h0, module_active}, 32'h1, "after disable");
        gate_check(2'b01);
        $display("switch timing test done");
        bus(1'b1, PCG_OFF_CTL4, 32'h00000008);
        gate_check(2'b00);
        do_reset();
        test_done();
    end
endmodule : test_pcg_top
`default_nettype wire
